// ---- common/lbc_defs.vh ----
`ifndef LBC_DEFS_VH
`define LBC_DEFS_VH
// bus states
`define LBC_ST_IDLE 2'h0
`define LBC_ST_STAT 2'h1
`define LBC_ST_CMD 2'h2
`define LBC_ST_HOLD 2'h3
// processor phases
`define LBC_PH1 1'b0
`define LBC_PH2 1'b1
// status encodings on the two status lines (s1,s0)
`define LBC_STAT_IDLE 2'h3
`define LBC_STAT_READ 2'h2
`define LBC_STAT_WRITE 2'h1
// system clock period and hold figures
`define LBC_CLK_NS 10
`define LBC_WDATA_HOLD_NS 10
`define LBC_WDATA_HOLD_CYC ((`LBC_WDATA_HOLD_NS+`LBC_CLK_NS-1)/`LBC_CLK_NS)
// widths
`define LBC_AW 24
`define LBC_DW 16
`endif

// ---- logic/lbc_sync2.v ----
`timescale 1ns/1ps
module lbc_sync2 (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire rst_val_i,
   input wire d_i,
   output wire q_o
);
   reg s1_reg;
   reg s2_reg;
   // flops clear to zero; rst_val_i flips sense so q_o resets to it
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
      end else begin
         s1_reg <= d_i ^ rst_val_i;
         s2_reg <= s1_reg;
      end
   end
   assign q_o = s2_reg ^ rst_val_i;
endmodule // lbc_sync2

// ---- logic/lbc_ready_sync.v ----
`timescale 1ns/1ps
`include "lbc_defs.vh"
module lbc_ready_sync (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire in_cmd_i,
   input wire phase_i,
   input wire sync_ready_n_i,
   input wire sync_ready_select_n_i,
   input wire async_ready_n_i,
   input wire async_ready_select_n_i,
   output wire ready_n_o
);
   reg sync_hit_reg;
   reg async_samp_reg;
   reg async_hit_reg;
   wire at_ph1_end;
   assign at_ph1_end = in_cmd_i && (phase_i == `LBC_PH1);
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync_hit_reg <= 1'b0;
         async_samp_reg <= 1'b0;
         async_hit_reg <= 1'b0;
      end else begin
         sync_hit_reg <= at_ph1_end && !sync_ready_n_i &&
            !sync_ready_select_n_i;
         async_samp_reg <= (phase_i == `LBC_PH2) && !async_ready_n_i &&
            !async_ready_select_n_i;
         // one clock to resolve, then line up with phase 2 of command
         async_hit_reg <= at_ph1_end && async_samp_reg;
      end
   end
   assign ready_n_o = !(sync_hit_reg || async_hit_reg);
endmodule // lbc_ready_sync

// ---- logic/lbc_bus_ctrl.v ----
`timescale 1ns/1ps
`include "lbc_defs.vh"
// Contract
// - in release state, address, data and status outputs float
// - grant acknowledge high while in release state
// - operations pipelined: start every two cycles, each spans three
// - next address may appear phase 2 of command; held phase 1
// - latch strobe gives one system clock of address hold
// - transceiver enable and direction timed to avoid contention
// - command delay sampled each edge after status until command active
// - command delay never moves latch strobe or transceiver controls
// - status lines return inactive after the status state
// - command state follows status, repeats until ready
// - ready ends the operation on the same clock for both
// - sync ready sampled at end of phase 1 of each command state
// - async ready sampled at command start, one clock to resolve
// - direction low for reads, high around writes
// - write data driven only from phase 2 of status
// - write data held one system clock after last command state
// - data floats phase 2 after write; stays driven write to write
// - request during write: finish, one idle, then release
// - system clock divided by two; each state one processor clock
// - status begins with a status line low in phase 1
module lbc_bus_ctrl (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire req_valid_i,
   input wire req_write_i,
   input wire [`LBC_AW-1:0] req_addr_i,
   input wire [`LBC_DW-1:0] req_wdata_i,
   output wire req_ready_o,
   output reg [`LBC_DW-1:0] rd_data_o,
   output reg rd_valid_o,
   input wire bus_request_i,
   output reg bus_grant_ack_o,
   output reg [`LBC_AW-1:0] addr_o,
   output wire addr_oe_o,
   output reg [`LBC_DW-1:0] data_o,
   output reg data_oe_o,
   input wire [`LBC_DW-1:0] data_i,
   output reg status_line_one_n_o,
   output reg status_line_zero_n_o,
   output wire status_oe_o,
   output reg addr_latch_o,
   output reg transceiver_enable_o,
   output reg transceiver_direction_o,
   output reg command_n_o,
   input wire command_delay_n_i,
   input wire sync_ready_n_i,
   input wire sync_ready_select_n_i,
   input wire async_ready_n_i,
   input wire async_ready_select_n_i,
   output wire phase_o
);
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg phase_reg;
   reg cur_wr_reg;
   reg prev_wr_reg;
   reg hold_idle_reg;
   reg cmd_on_reg;
   reg [`LBC_DW-1:0] wdata_reg;
   wire bus_req_s;
   wire cmd_dly_s;
   wire sync_ready_n_s;
   wire sync_ready_n_sel_s;
   wire async_ready_n_s;
   wire async_ready_n_sel_s;
   wire ready_n;
   wire in_cmd;
   wire last_cmd;
   wire [`LBC_DW-1:0] data_s;

   // pins from outside the clock domain pass two flops
   lbc_sync2 u_sreq (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .rst_val_i(1'b0), .d_i(~bus_request_i), .q_o(bus_req_s));
   lbc_sync2 u_sdly (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .rst_val_i(1'b1), .d_i(command_delay_n_i), .q_o(cmd_dly_s));
   lbc_sync2 u_ssr (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .rst_val_i(1'b1), .d_i(sync_ready_n_i), .q_o(sync_ready_n_s));
   lbc_sync2 u_sss (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .rst_val_i(1'b1), .d_i(sync_ready_select_n_i), .q_o(sync_ready_n_sel_s));
   lbc_sync2 u_sar (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .rst_val_i(1'b1), .d_i(async_ready_n_i), .q_o(async_ready_n_s));
   lbc_sync2 u_sas (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .rst_val_i(1'b1), .d_i(async_ready_select_n_i), .q_o(async_ready_n_sel_s));

   genvar gi;
   generate
      for (gi = 0; gi < `LBC_DW; gi = gi + 1) begin : g_dsync
         lbc_sync2 u_d (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
            .rst_val_i(1'b1), .d_i(~data_i[gi]), .q_o(data_s[gi]));
      end
   endgenerate

   assign in_cmd = (state_reg == `LBC_ST_CMD);

   lbc_ready_sync u_rdy (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .in_cmd_i(in_cmd),
      .phase_i(phase_reg),
      .sync_ready_n_i(sync_ready_n_s),
      .sync_ready_select_n_i(sync_ready_n_sel_s),
      .async_ready_n_i(async_ready_n_s),
      .async_ready_select_n_i(async_ready_n_sel_s),
      .ready_n_o(ready_n)
   );

   // last command ends on phase 2 with ready seen
   assign last_cmd = in_cmd && (phase_reg == `LBC_PH2) && !ready_n;
   assign phase_o = phase_reg;
   assign req_ready_o = (phase_reg == `LBC_PH2) && !bus_req_s &&
      !hold_idle_reg &&
      ((state_reg == `LBC_ST_IDLE) || (state_reg == `LBC_ST_HOLD) ||
      last_cmd);
   assign addr_oe_o = (state_reg != `LBC_ST_HOLD);
   assign status_oe_o = (state_reg != `LBC_ST_HOLD);

   // state walk on processor clock boundary
   always @* begin
      state_next = state_reg;
      if (phase_reg == `LBC_PH2) begin
         case (state_reg)
            `LBC_ST_IDLE, `LBC_ST_HOLD: begin
               if (bus_req_s)
                  state_next = `LBC_ST_HOLD;
               else if (req_valid_i && !bus_req_s)
                  state_next = `LBC_ST_STAT;
               else if (!bus_req_s)
                  state_next = `LBC_ST_IDLE;
            end
            `LBC_ST_STAT: state_next = `LBC_ST_CMD;
            `LBC_ST_CMD: begin
               if (last_cmd) begin
                  if (req_valid_i && !bus_req_s)
                     state_next = `LBC_ST_STAT;
                  else
                     state_next = `LBC_ST_IDLE;
               end
            end
            default: state_next = `LBC_ST_IDLE;
         endcase
      end
   end

   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= `LBC_ST_IDLE;
         phase_reg <= `LBC_PH1;
         cur_wr_reg <= 1'b0;
         prev_wr_reg <= 1'b0;
         hold_idle_reg <= 1'b0;
         wdata_reg <= {`LBC_DW{1'b0}};
         addr_o <= {`LBC_AW{1'b0}};
      end else begin
         phase_reg <= ~phase_reg;
         state_reg <= state_next;
         // one idle after a write before release
         if (phase_reg == `LBC_PH2)
            hold_idle_reg <= last_cmd && cur_wr_reg && bus_req_s;
         if (last_cmd)
            prev_wr_reg <= cur_wr_reg;
         else if (state_reg == `LBC_ST_IDLE && phase_reg == `LBC_PH2)
            prev_wr_reg <= 1'b0;
         // next address issued at phase 2 of command, idle or release
         if (req_ready_o && req_valid_i) begin
            cur_wr_reg <= req_write_i;
            wdata_reg <= req_wdata_i;
            addr_o <= req_addr_i;
         end
      end
   end

   // status lines, latch strobe, transceivers, command, data
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_line_one_n_o <= 1'b1;
         status_line_zero_n_o <= 1'b1;
         addr_latch_o <= 1'b0;
         transceiver_enable_o <= 1'b0;
         transceiver_direction_o <= 1'b1;
         command_n_o <= 1'b1;
         cmd_on_reg <= 1'b0;
         data_o <= {`LBC_DW{1'b0}};
         data_oe_o <= 1'b0;
         bus_grant_ack_o <= 1'b0;
         rd_data_o <= {`LBC_DW{1'b0}};
         rd_valid_o <= 1'b0;
      end else begin
         bus_grant_ack_o <= (state_next == `LBC_ST_HOLD);
         // status low only through status state
         if (state_next == `LBC_ST_STAT && phase_reg == `LBC_PH2) begin
            {status_line_one_n_o, status_line_zero_n_o} <=
               req_write_i ? `LBC_STAT_WRITE : `LBC_STAT_READ;
         end else if (state_reg == `LBC_ST_STAT &&
            phase_reg == `LBC_PH2) begin
            status_line_one_n_o <= 1'b1;
            status_line_zero_n_o <= 1'b1;
         end
         // latch pulse in phase 1 of status only
         addr_latch_o <= (state_next == `LBC_ST_STAT) &&
            (phase_reg == `LBC_PH2);
         if (state_reg == `LBC_ST_STAT)
            transceiver_direction_o <= cur_wr_reg;
         else if (state_reg != `LBC_ST_CMD ||
            (req_ready_o && req_valid_i && req_write_i))
            transceiver_direction_o <= 1'b1;
         // enable spans command states, not command delay
         transceiver_enable_o <= (state_reg == `LBC_ST_STAT &&
            phase_reg == `LBC_PH2) || (in_cmd && !last_cmd);
         if (in_cmd && !cmd_on_reg && !cmd_dly_s)
            cmd_on_reg <= 1'b1;
         else if (last_cmd)
            cmd_on_reg <= 1'b0;
         command_n_o <= !(in_cmd && !last_cmd &&
            (cmd_on_reg || !cmd_dly_s));
         // write data from phase 2 of status
         if (state_reg == `LBC_ST_STAT && phase_reg == `LBC_PH1 &&
            cur_wr_reg) begin
            data_o <= wdata_reg;
            data_oe_o <= 1'b1;
         end else if (state_next == `LBC_ST_HOLD) begin
            data_oe_o <= 1'b0;
         end else if (!in_cmd && state_reg != `LBC_ST_STAT &&
            phase_reg == `LBC_PH1 && prev_wr_reg) begin
            // held through phase 1, float in phase 2
            data_oe_o <= 1'b0;
         end else if (state_reg == `LBC_ST_STAT && !cur_wr_reg) begin
            data_oe_o <= 1'b0;
         end
         rd_valid_o <= last_cmd && !cur_wr_reg;
         if (last_cmd && !cur_wr_reg)
            rd_data_o <= data_s;
      end
   end
endmodule // lbc_bus_ctrl

// ---- sim/lbc_bus_ctrl_props.sv ----
`timescale 1ns/1ps
module lbc_bus_ctrl_props (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire bus_request_i,
   input wire bus_grant_ack_o,
   input wire addr_oe_o,
   input wire data_oe_o,
   input wire status_oe_o,
   input wire status_line_one_n_o,
   input wire status_line_zero_n_o,
   input wire addr_latch_o,
   input wire transceiver_enable_o,
   input wire transceiver_direction_o,
   input wire command_n_o,
   input wire phase_o
);
   wire st = !(status_line_one_n_o && status_line_zero_n_o);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   chk_release_float: assert property (bus_grant_ack_o |->
      !addr_oe_o && !data_oe_o && !status_oe_o) else $error("release drives");
   chk_grant_on_req: assert property ($rose(bus_grant_ack_o) |->
      !bus_request_i && !st) else $error("grant without request");
   chk_status_width: assert property ($rose(st) |=> st ##1 !st)
      else $error("status width");
   chk_status_phase: assert property ($rose(st) |-> !phase_o)
      else $error("status not in phase 1");
   chk_latch_pulse: assert property ($rose(st) |->
      addr_latch_o ##1 !addr_latch_o) else $error("latch pulse");
   chk_op_spacing: assert property ($rose(st) |=>
      (!$rose(st))[*3]) else $error("operations too close");
   chk_enable_timing: assert property ($rose(st) |=>
      !transceiver_enable_o ##1 transceiver_enable_o)
      else $error("transceiver enable timing");
   chk_dir_read: assert property (st && $past(st) &&
      !status_line_zero_n_o |-> !transceiver_direction_o)
      else $error("direction high in read");
   chk_dir_write: assert property (st && !status_line_one_n_o |->
      transceiver_direction_o) else $error("direction low in write");
   chk_wdata_start: assert property ($rose(data_oe_o) |->
      !status_line_one_n_o && $past(!status_line_one_n_o))
      else $error("write data early");
   chk_cmd_after_stat: assert property ($fell(command_n_o) |-> !st)
      else $error("command during status");
   cover property ($rose(bus_grant_ack_o));
   cover property (st && !status_line_one_n_o);
   cover property (st && !status_line_zero_n_o);
endmodule // lbc_bus_ctrl_props
bind lbc_bus_ctrl lbc_bus_ctrl_props i_lbc_bus_ctrl_props (.mclk_i,
   .sys_rst_i, .bus_request_i, .bus_grant_ack_o, .addr_oe_o, .data_oe_o,
   .status_oe_o, .status_line_one_n_o, .status_line_zero_n_o,
   .addr_latch_o, .transceiver_enable_o, .transceiver_direction_o,
   .command_n_o, .phase_o);

// ---- sim/lbc_far_side.sv ----
`timescale 1ns/1ps
`include "lbc_defs.vh"
module lbc_far_side (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire [`LBC_AW-1:0] addr_i,
   input wire [`LBC_DW-1:0] wdata_i,
   input wire data_oe_i,
   input wire stat_zero_n_i,
   input wire latch_i,
   input wire command_n_i,
   input wire [2:0] wait_i,
   input wire [2:0] delay_i,
   input wire async_i,
   output reg [`LBC_DW-1:0] data_o,
   output wire command_delay_n_o,
   output wire sync_ready_n_o,
   output wire sync_sel_n_o,
   output wire async_ready_n_o,
   output wire async_sel_n_o,
   output reg [`LBC_AW-1:0] wr_addr_o,
   output reg [`LBC_DW-1:0] wr_data_o,
   output reg [7:0] wr_cnt_o
);
   reg [5:0] cnt_reg;
   reg [`LBC_AW-1:0] addr_reg;
   reg rd_reg;
   reg cap_reg;
   wire [5:0] due = {2'h0, wait_i, 1'b0};
   assign sync_sel_n_o = async_i;
   assign async_sel_n_o = !async_i;
   // ready after wait count; design sees pins two clocks late
   assign sync_ready_n_o = latch_i ? (wait_i != 3'h0) :
      (cnt_reg + 6'h1 < due);
   // async one-cycle pulse, high through status phase 1
   assign async_ready_n_o = latch_i || (cnt_reg + 6'h2 != due);
   assign command_delay_n_o = latch_i ? (delay_i != 3'h0) :
      (cnt_reg < {3'h0, delay_i});
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 6'h3f;
         rd_reg <= 1'b0;
         cap_reg <= 1'b1;
         data_o <= 16'h0;
         wr_cnt_o <= 8'h0;
      end else begin
         if (latch_i) begin
            cnt_reg <= 6'h0;
            addr_reg <= addr_i;
            rd_reg <= !stat_zero_n_i;
            cap_reg <= 1'b0;
         end else if (cnt_reg != 6'h3f) begin
            cnt_reg <= cnt_reg + 6'h1;
         end
         if (!command_n_i && data_oe_i && !cap_reg && !latch_i) begin
            wr_addr_o <= addr_reg;
            wr_data_o <= wdata_i;
            wr_cnt_o <= wr_cnt_o + 8'h1;
            cap_reg <= 1'b1;
         end
         // released bus toggles so stale data never looks valid
         if (latch_i && !stat_zero_n_i) begin
            data_o <= ~(addr_i[15:0] ^ 16'h5a5a);
         end else if (rd_reg && cnt_reg <= due + 6'h8) begin
            data_o <= ~(addr_reg[15:0] ^ 16'h5a5a);
         end else begin
            data_o <= ~data_o;
         end
      end
   end
endmodule // lbc_far_side

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "lbc_defs.vh"
module tb_top;
   typedef struct packed {logic wr; logic [23:0] a; logic [15:0] d;
      logic [2:0] w; logic [2:0] dl; logic as;} lbc_row_t;
   lbc_row_t rows [6] = '{'{0, 24'h10, 0, 0, 0, 0},
      '{1, 24'h12, 16'h1234, 0, 0, 0}, '{0, 24'habcd, 0, 2, 0, 1},
      '{1, 24'hfffffe, 16'hbeef, 2, 2, 1}, '{0, 24'h800000, 0, 1, 3, 0},
      '{1, 24'h0, 16'hffff, 1, 1, 0}};
   logic mclk_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0;
   logic bus_request_i = 1, as_s = 0;
   logic [23:0] req_addr_i = 0;
   logic [15:0] req_wdata_i = 0;
   logic [2:0] w_s = 0, dl_s = 0;
   wire rdy, rdv, gnt, aoe, doe, s1, s0, soe, ale, transceiver_enable, dir, cmd, ph;
   wire cdl, sr, srs, ar, ars;
   wire [15:0] rdd, dout, din, wrd;
   wire [23:0] addr, wra;
   wire [7:0] wrc;
   int mismatches = 0, total_checks = 0, k;
   logic [7:0] c0;
   lbc_bus_ctrl i_lbc_bus_ctrl (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .req_valid_i(req_valid_i), .req_write_i(req_write_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_ready_o(rdy), .rd_data_o(rdd), .rd_valid_o(rdv),
      .bus_request_i(bus_request_i), .bus_grant_ack_o(gnt), .addr_o(addr),
      .addr_oe_o(aoe), .data_o(dout), .data_oe_o(doe), .data_i(din),
      .status_line_one_n_o(s1), .status_line_zero_n_o(s0),
      .status_oe_o(soe), .addr_latch_o(ale), .transceiver_enable_o(transceiver_enable),
      .transceiver_direction_o(dir), .command_n_o(cmd),
      .command_delay_n_i(cdl), .sync_ready_n_i(sr),
      .sync_ready_select_n_i(srs), .async_ready_n_i(ar),
      .async_ready_select_n_i(ars), .phase_o(ph));
   lbc_far_side i_lbc_far_side (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .addr_i(addr), .wdata_i(dout), .data_oe_i(doe), .stat_zero_n_i(s0),
      .latch_i(ale), .command_n_i(cmd), .wait_i(w_s), .delay_i(dl_s),
      .async_i(as_s), .data_o(din), .command_delay_n_o(cdl),
      .sync_ready_n_o(sr), .sync_sel_n_o(srs), .async_ready_n_o(ar),
      .async_sel_n_o(ars), .wr_addr_o(wra), .wr_data_o(wrd),
      .wr_cnt_o(wrc));
   initial forever #5 mclk_i = ~mclk_i;
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // kind 0 read data, 1 write seen, 2 grant
   task wait_for(input int kind);
      int i;
      for (i = 0; i < 300; i++) begin
         @(negedge mclk_i);
         if (kind == 0 ? rdv === 1'b1 : kind == 1 ? wrc !== c0 :
            gnt === 1'b1) break;
      end
      if (i == 300) begin
         chk("wait", 1, 0);
         end_of_test;
      end
   endtask
   task issue(input lbc_row_t r);
      int i;
      @(negedge mclk_i);
      {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, r.wr,
         r.a, r.d};
      {w_s, dl_s, as_s} = {r.w, r.dl, r.as};
      for (i = 0; i < 300; i++) begin
         #1;
         if (rdy === 1'b1) break;
         @(negedge mclk_i);
      end
      if (i == 300) begin
         chk("taken", 1, 0);
         end_of_test;
      end
      @(negedge mclk_i);
      req_valid_i = 0;
   endtask
   task run(input lbc_row_t r);
      c0 = wrc;
      issue(r);
      wait_for(r.wr ? 1 : 0);
      if (r.wr) begin
         chk("wr_addr", r.a, wra);
         chk("wr_data", r.d, wrd);
      end else chk("rd_data", r.a[15:0] ^ 16'h5a5a, rdd);
   endtask
   initial begin
      repeat (20) @(negedge mclk_i);
      chk("rst_outs", 8'hce, {s1, s0, gnt, doe, dir, cmd, aoe, 1'b0});
      $display("test reset done");
      sys_rst_i = 0;
      foreach (rows[k]) begin
         run(rows[k]);
         $display("test row %0d done", k);
      end
      c0 = wrc;
      issue(rows[1]);
      issue(rows[5]);
      issue(rows[0]);
      wait_for(0);
      chk("b2b_count", c0 + 8'h2, wrc);
      chk("b2b_data", rows[5].d, wrd);
      chk("b2b_rd", 16'h5a4a, rdd);
      $display("test back to back done");
      c0 = wrc;
      issue(rows[1]);
      bus_request_i = 0;
      wait_for(2);
      chk("hold_wr", c0 + 8'h1, wrc);
      chk("hold_float", 0, {aoe, doe, soe});
      req_valid_i = 1;
      repeat (6) @(negedge mclk_i);
      chk("hold_refuse", 0, rdy);
      bus_request_i = 1;
      run(rows[2]);
      chk("hold_left", 0, gnt);
      $display("test hold done");
      end_of_test;
   end
endmodule // tb_top
